// *** core/pulse_gen_consts.vh ***
// constants for the pulse generator and width capture block
// assumes a 32-bit axi4-lite register bus with word-aligned offsets
`ifndef PULSE_GEN_CONSTS_VH
`define PULSE_GEN_CONSTS_VH

// register byte offsets
`define OFS_MODE 8'h00
`define OFS_CAPCTRL 8'h04
`define OFS_PRESCALE 8'h08
`define OFS_OUTCTRL 8'h0C
`define OFS_PERIOD 8'h10
`define OFS_DUTY 8'h14
`define OFS_COUNTER 8'h18
`define OFS_STATUS 8'h1C
`define OFS_MASK 8'h20

// mode control field values (bits 1:0)
`define MODE_STOP 2'h0
`define MODE_FREE 2'h1
`define MODE_RESTART 2'h2
`define MODE_PULSE 2'h3

// capture control field values (bits 1:0)
`define CAP_ONE_REG 2'h0
`define CAP_DUAL_INPUT 2'h1
`define CAP_TWO_REG 2'h2

// prescaler/edge config field positions
`define PRE_CLK_LO 0
`define EDGE_A_LO 4
`define EDGE_B_LO 6

// edge select codes
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h3

// status bit positions
`define ST_IRQ_A 0
`define ST_IRQ_B 1
`define ST_WRAP 2

// count clock dividers of the system clock, per select code
`define DIV_SEL0 16'h0002
`define DIV_SEL1 16'h0004
`define DIV_SEL2 16'h0100
`define DIV_SEL3 16'h0008

// reset values
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_COUNT_MAX 16'hFFFF

`endif

// *** core/edge_filter.v ***
// two-sample noise filter and edge detector for one capture pin
// assumes the pin is asynchronous; tick is a one-cycle count clock enable
`timescale 1ns/1ns
module edge_filter (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // sampling enable and edge select
   input wire tick,
   input wire [1:0] edge_sel,
   // pin
   input wire pin,
   // detected edges, one-cycle pulses
   output reg sel_edge,
   output reg inv_edge
);
`include "pulse_gen_consts.vh"

reg sync1;
reg sync2;
reg samp1;
reg stable;
wire rise;
wire fall;

// two flops before any logic reads the pin
always @(posedge aclk) begin
   if (!aresetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
   end else begin
      sync1 <= pin;
      sync2 <= sync1;
   end
end

// new level must be seen on two consecutive count clock samples
always @(posedge aclk) begin
   if (!aresetn) begin
      samp1 <= 1'b0;
      stable <= 1'b0;
   end else if (tick) begin
      samp1 <= sync2;
      if (sync2 == samp1)
         stable <= samp1;
   end
end

assign rise = tick && (sync2 == samp1) && samp1 && !stable;
assign fall = tick && (sync2 == samp1) && !samp1 && stable;

// decode edge select; code 10 matches nothing
always @(posedge aclk) begin
   if (!aresetn) begin
      sel_edge <= 1'b0;
      inv_edge <= 1'b0;
   end else begin
      case (edge_sel)
         `EDGE_FALL: begin
            sel_edge <= fall;
            inv_edge <= rise;
         end
         `EDGE_RISE: begin
            sel_edge <= rise;
            inv_edge <= fall;
         end
         `EDGE_BOTH: begin
            sel_edge <= rise | fall;
            inv_edge <= 1'b0;
         end
         default: begin
            sel_edge <= 1'b0;
            inv_edge <= 1'b0;
         end
      endcase
   end
end

endmodule // edge_filter

// *** core/pulse_gen_and_width_capture.v ***
// pulse generator and pulse width capture on a 16-bit counter
// assumes an axi4-lite master on aclk and asynchronous capture pins
// Behaviour
// - period is period value plus one, high width duty plus one count clocks.
// - width measurement runs free or restarts on each first-input edge.
// - captures need the new level on two consecutive count clock samples.
// - single-capture mode: first-input edge loads register b, raises irq b.
// - dual-input mode: second-input edge loads register a, raises irq a.
// - two-register mode: selected edge loads b, opposite edge loads a.
// - restart mode: edge loads register b, then clears the counter.
// - wrap flag stays set until software clears it.
// - edge select decodes 00 falling, 01 rising, 11 both.
// - pulse mode drives a rectangular wave on the timer output pin.
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module pulse_gen_and_width_capture (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // axi4-lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // capture pins
   input wire capture_input_a,
   input wire capture_input_b,
   // timer output and interrupt
   output reg timer_output_pin,
   output reg irq
);
`include "pulse_gen_consts.vh"

// registers
reg [1:0] timer_mode_ctrl;
reg [1:0] capture_compare_ctrl;
reg [7:0] prescaler_edge_config;
reg toggle_on_duty_match;
reg [15:0] period_capture_reg_a;
reg [15:0] duty_capture_reg_b;
reg [15:0] main_counter;
reg [2:0] status;
reg [2:0] mask;
reg [15:0] div_cnt;
reg tick;
reg [7:0] aw_addr;
reg aw_held;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_held;

wire [1:0] edge_sel_a;
wire [1:0] edge_sel_b;
wire sel_a;
wire inv_a;
wire sel_b;
wire inv_b;
wire running;
wire do_write;
wire [2:0] next_status;
wire [15:0] next_count;
reg [2:0] set_bits;
reg [31:0] rd_word;
reg [1:0] rd_resp;
reg [15:0] div_limit;

assign edge_sel_a = prescaler_edge_config[`EDGE_A_LO+1:`EDGE_A_LO];
assign edge_sel_b = prescaler_edge_config[`EDGE_B_LO+1:`EDGE_B_LO];
assign running = (timer_mode_ctrl != `MODE_STOP);
assign do_write = aw_held && w_held && !s_axi_bvalid;
assign next_count = main_counter + 16'h0001;

// merge the low byte lane of a write into an 8-bit field
function [7:0] lane0;
   input [7:0] old;
   input [31:0] data;
   input [3:0] strb;
   begin
      lane0 = strb[0] ? data[7:0] : old;
   end
endfunction

// merge the two low byte lanes into a 16-bit field
function [15:0] lane01;
   input [15:0] old;
   input [31:0] data;
   input [3:0] strb;
   begin
      lane01 = {strb[1] ? data[15:8] : old[15:8],
                strb[0] ? data[7:0] : old[7:0]};
   end
endfunction

// count clock select from the prescaler field
always @* begin
   case (prescaler_edge_config[`PRE_CLK_LO+1:`PRE_CLK_LO])
      2'h0: div_limit = `DIV_SEL0;
      2'h1: div_limit = `DIV_SEL1;
      2'h2: div_limit = `DIV_SEL2;
      default: div_limit = `DIV_SEL3;
   endcase
end

// count clock enable; external-edge clocking is replaced by a fixed rate
always @(posedge aclk) begin
   if (!aresetn) begin
      div_cnt <= `RST_WORD;
      tick <= 1'b0;
   end else if (!running) begin
      div_cnt <= `RST_WORD;
      tick <= 1'b0;
   end else if (div_cnt >= div_limit - 16'h0001) begin
      div_cnt <= `RST_WORD;
      tick <= 1'b1;
   end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick <= 1'b0;
   end
end

// pin filters, both sampled at the count clock
edge_filter filt_a (
   .aclk(aclk),
   .aresetn(aresetn),
   .tick(tick),
   .edge_sel(edge_sel_a),
   .pin(capture_input_a),
   .sel_edge(sel_a),
   .inv_edge(inv_a)
);

edge_filter filt_b (
   .aclk(aclk),
   .aresetn(aresetn),
   .tick(tick),
   .edge_sel(edge_sel_b),
   .pin(capture_input_b),
   .sel_edge(sel_b),
   .inv_edge(inv_b)
);

// counter; captures and restart act on the filtered edge pulse
always @(posedge aclk) begin
   if (!aresetn) begin
      main_counter <= `RST_WORD;
      timer_output_pin <= 1'b0;
   end else if (!running) begin
      main_counter <= `RST_WORD;
      timer_output_pin <= 1'b0;
   end else if (timer_mode_ctrl == `MODE_PULSE) begin
      if (tick) begin
         // period = period value + 1 counts
         if (main_counter == period_capture_reg_a)
            main_counter <= `RST_WORD;
         else
            main_counter <= next_count;
         // high from zero through duty match, low after it
         if (main_counter == period_capture_reg_a)
            timer_output_pin <= 1'b1;
         else if (toggle_on_duty_match &&
                  main_counter == duty_capture_reg_b)
            timer_output_pin <= 1'b0;
      end
   end else if (timer_mode_ctrl == `MODE_RESTART && sel_a) begin
      main_counter <= `RST_WORD;
   end else if (tick) begin
      main_counter <= next_count;
   end
end

// capture registers; software writes only when not capturing, and the period register only when stopped
always @(posedge aclk) begin
   if (!aresetn) begin
      period_capture_reg_a <= `RST_WORD;
      duty_capture_reg_b <= `RST_WORD;
   end else if (running && timer_mode_ctrl != `MODE_PULSE) begin
      if (sel_a)
         duty_capture_reg_b <= main_counter;
      if (capture_compare_ctrl == `CAP_DUAL_INPUT && sel_b)
         period_capture_reg_a <= main_counter;
      else if (capture_compare_ctrl == `CAP_TWO_REG && inv_a)
         period_capture_reg_a <= main_counter;
   end else if (do_write) begin
      if (aw_addr == `OFS_PERIOD && !running)
         period_capture_reg_a <= lane01(period_capture_reg_a,
                                        w_data, w_strb);
      if (aw_addr == `OFS_DUTY)
         duty_capture_reg_b <= lane01(duty_capture_reg_b, w_data, w_strb);
   end
end

// event sources for the sticky status bits
always @* begin
   set_bits = 3'h0;
   if (running && timer_mode_ctrl == `MODE_PULSE) begin
      set_bits[`ST_IRQ_A] = tick && main_counter == period_capture_reg_a;
      set_bits[`ST_IRQ_B] = tick && main_counter == duty_capture_reg_b;
   end else if (running) begin
      set_bits[`ST_IRQ_B] = sel_a;
      set_bits[`ST_IRQ_A] = capture_compare_ctrl == `CAP_DUAL_INPUT
                            && sel_b;
      set_bits[`ST_WRAP] = tick && main_counter == `RST_COUNT_MAX &&
                           !(timer_mode_ctrl == `MODE_RESTART && sel_a);
   end
end

// write-one-to-clear, but a new event wins over the clear
assign next_status = (do_write && aw_addr == `OFS_STATUS) ?
   ((status & ~w_data[2:0]) | set_bits) : (status | set_bits);

// status, mask and the interrupt line
always @(posedge aclk) begin
   if (!aresetn) begin
      status <= 3'h0;
      irq <= 1'b0;
   end else begin
      status <= next_status;
      irq <= |(next_status & ~mask);
   end
end

// software control registers
always @(posedge aclk) begin
   if (!aresetn) begin
      timer_mode_ctrl <= `MODE_STOP;
      capture_compare_ctrl <= `CAP_ONE_REG;
      prescaler_edge_config <= `RST_BYTE;
      toggle_on_duty_match <= 1'b0;
      mask <= 3'h7;
   end else if (do_write) begin
      case (aw_addr)
         `OFS_MODE:
            timer_mode_ctrl <= w_strb[0] ? w_data[1:0]
                                         : timer_mode_ctrl;
         `OFS_CAPCTRL:
            capture_compare_ctrl <= w_strb[0] ? w_data[1:0]
                                              : capture_compare_ctrl;
         `OFS_PRESCALE:
            prescaler_edge_config <= lane0(prescaler_edge_config,
                                           w_data, w_strb) & 8'hF3;
         `OFS_OUTCTRL:
            if (w_strb[0])
               toggle_on_duty_match <= w_data[0];
         `OFS_MASK:
            if (w_strb[0])
               mask <= w_data[2:0];
         default: ;
      endcase
   end
end

// axi write channels: address and data taken in either order
always @(posedge aclk) begin
   if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= `RST_BYTE;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
   end else begin
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= {s_axi_awaddr[7:2], 2'h0};
         s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end
      if (do_write) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (aw_addr > `OFS_MASK) ? 2'h2 : 2'h0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end
   end
end

// read decode
always @* begin
   rd_word = 32'h00000000;
   rd_resp = 2'h0;
   case ({s_axi_araddr[7:2], 2'h0})
      `OFS_MODE: rd_word[1:0] = timer_mode_ctrl;
      `OFS_CAPCTRL: rd_word[1:0] = capture_compare_ctrl;
      `OFS_PRESCALE: rd_word[7:0] = prescaler_edge_config;
      `OFS_OUTCTRL: rd_word[0] = toggle_on_duty_match;
      `OFS_PERIOD: rd_word[15:0] = period_capture_reg_a;
      `OFS_DUTY: rd_word[15:0] = duty_capture_reg_b;
      `OFS_COUNTER: rd_word[15:0] = main_counter;
      `OFS_STATUS: rd_word[2:0] = status;
      `OFS_MASK: rd_word[2:0] = mask;
      default: rd_resp = 2'h2; // unmapped answers slverr
   endcase
end

// axi read channel, one read at a time
always @(posedge aclk) begin
   if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
   end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_resp;
   end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
   end
end

endmodule // pulse_gen_and_width_capture

// *** test/pulse_gen_sva.sv ***
// assertion checker for the register bus, interrupt and reset of the block
// assumes binding to the top module, all in the aclk domain
`timescale 1ns/1ns
module pulse_gen_sva (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins
   input wire logic capture_input_a,
   input wire logic capture_input_b,
   input wire logic timer_output_pin,
   input wire logic irq
);
   logic bad_aw;
   // remember whether the open write aims past the last register
   always @(posedge aclk) begin
      if (s_axi_awvalid && s_axi_awready)
         bad_aw <= ({s_axi_awaddr[7:2], 2'h0} > 8'h20);
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_rd_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_wr_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_aw_busy;
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2];
   endproperty
   a_aw_busy: assert property (p_aw_busy) else $error("awready too soon");
   property p_rd_bad;
      s_axi_arvalid && s_axi_arready && {s_axi_araddr[7:2], 2'h0} > 8'h20
         |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
   endproperty
   a_rd_bad: assert property (p_rd_bad) else $error("unmapped read ok");
   property p_wr_bad;
      s_axi_bvalid && bad_aw |-> s_axi_bresp == 2'h2;
   endproperty
   a_wr_bad: assert property (p_wr_bad) else $error("unmapped write ok");
   property p_rst;
      $rose(aresetn) |-> !irq && !timer_output_pin && s_axi_awready
         && !s_axi_bvalid && !s_axi_rvalid;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   // a sticky status bit only goes away through a bus write
   property p_irq_fall;
      $fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq lost");
   c_irq: cover property ($rose(irq));
   c_bad: cover property (s_axi_bvalid && bad_aw);
   c_pin: cover property ($rose(timer_output_pin));
endmodule // pulse_gen_sva
bind pulse_gen_and_width_capture pulse_gen_sva i_pulse_gen_sva (.*);

// *** test/pin_model.sv ***
// far side model: drives the two capture pins with timed pulses
// assumes pins idle low and change just after a rising aclk edge
`timescale 1ns/1ns
module pin_model (
   // clock
   input wire aclk,
   // capture pins, only ever driven toward the block
   output reg capture_input_a,
   output reg capture_input_b
);
   // both pins start low so no edge is seen at start
   initial begin
      capture_input_a = 1'b0;
      capture_input_b = 1'b0;
   end
   // high pulse of len cycles on pin a (sel 0) or pin b (sel 1)
   task pulse(input sel, input integer len);
      begin
         @(posedge aclk);
         if (sel) capture_input_b <= 1'b1;
         else capture_input_a <= 1'b1;
         repeat (len) @(posedge aclk);
         capture_input_a <= 1'b0;
         capture_input_b <= 1'b0;
      end
   endtask
endmodule // pin_model

// *** test/testbench.sv ***
// self-checking bench: bus tasks plus pulse and capture scenarios
// assumes the design header is on the include path
`timescale 1ns/1ns
`include "pulse_gen_consts.vh"
module testbench;
   reg aclk, aresetn;
   reg [7:0] s_axi_awaddr, s_axi_araddr;
   reg [31:0] s_axi_wdata;
   reg [3:0] s_axi_wstrb;
   reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, capture_input_a, capture_input_b, timer_output_pin, irq;
   integer bad_count, total_checks, h, l, e;
   reg [31:0] v, w;
   pulse_gen_and_width_capture i_pulse_gen_and_width_capture (.*);
   pin_model i_pin_model (.*);
   // 250 MHz clock
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   task chk(input [31:0] exp, input [31:0] got, input [63:0] nm);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", total_checks, bad_count);
         if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // a spent wait bound ends the run at once
   task tmo(input integer n);
      if (n >= 500) begin
         bad_count = bad_count + 1;
         $display("mismatch wait expected done seen timeout");
         print_verdict;
      end
   endtask
   task wr(input [7:0] a, input [31:0] d, input [1:0] er);
      integer n;
      begin
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         n = 0;
         @(posedge aclk);
         while (!s_axi_bvalid && n < 500) begin
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n = n + 1;
            @(posedge aclk);
         end
         s_axi_bready <= 1'b0;
         tmo(n);
         chk({30'h0, er}, {30'h0, s_axi_bresp}, "bresp");
      end
   endtask
   task rd(input [7:0] a, input [1:0] er, output [31:0] d);
      integer n;
      begin
         @(posedge aclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         n = 0;
         @(posedge aclk);
         while (!s_axi_rvalid && n < 500) begin
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n = n + 1;
            @(posedge aclk);
         end
         s_axi_rready <= 1'b0;
         tmo(n);
         d = s_axi_rdata;
         chk({30'h0, er}, {30'h0, s_axi_rresp}, "rresp");
      end
   endtask
   task rchk(input [7:0] a, input [31:0] exp);
      begin
         rd(a, 2'h0, v);
         chk(exp, v, "rdata");
      end
   endtask
   // stop first so the setup order is control, clock, then mode
   task cfg(input [1:0] c, input [7:0] p, input [1:0] m);
      begin
         wr(`OFS_MODE, 32'h0, 2'h0);
         wr(`OFS_CAPCTRL, {30'h0, c}, 2'h0);
         wr(`OFS_PRESCALE, {24'h0, p}, 2'h0);
         wr(`OFS_STATUS, 32'h7, 2'h0);
         wr(`OFS_MODE, {30'h0, m}, 2'h0);
      end
   endtask
   // high and low run of the output in aclk cycles, from a rising edge
   task meas;
      integer n;
      begin
         for (n = 0; n < 500 && timer_output_pin !== 1'b0; n = n + 1)
            @(posedge aclk);
         tmo(n);
         for (n = 0; n < 500 && timer_output_pin !== 1'b1; n = n + 1)
            @(posedge aclk);
         tmo(n);
         for (h = 0; h < 500 && timer_output_pin === 1'b1; h = h + 1)
            @(posedge aclk);
         for (l = 0; l < 500 && timer_output_pin === 1'b0; l = l + 1)
            @(posedge aclk);
         tmo(l);
      end
   endtask
   // main sequence; count tick is aclk/2 with clock select 0
   initial begin
      bad_count = 0;
      total_checks = 0;
      aresetn = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(`OFS_MASK, 32'h7);
      rchk(`OFS_STATUS, 32'h0);
      rd(8'h24, 2'h2, v);
      chk(32'h0, v, "rdata");
      wr(8'h24, 32'h1, 2'h2);
      $display("test reset done");
      cfg(`CAP_ONE_REG, 8'h00, `MODE_STOP);
      wr(`OFS_PERIOD, 32'h9, 2'h0);
      wr(`OFS_DUTY, 32'h3, 2'h0);
      wr(`OFS_OUTCTRL, 32'h1, 2'h0);
      wr(`OFS_MODE, {30'h0, `MODE_PULSE}, 2'h0);
      meas;
      chk(32'd8, h, "high");
      chk(32'd12, l, "low");
      rchk(`OFS_STATUS, 32'h3);
      wr(`OFS_PERIOD, 32'h14, 2'h0);
      meas;
      chk(32'd12, l, "low");
      wr(`OFS_OUTCTRL, 32'h0, 2'h0);
      wr(`OFS_MASK, 32'h7, 2'h0);
      wr(`OFS_DUTY, 32'h5, 2'h0);
      repeat (2) @(posedge aclk);
      wr(`OFS_OUTCTRL, 32'h1, 2'h0);
      wr(`OFS_STATUS, 32'h2, 2'h0);
      wr(`OFS_MASK, 32'h5, 2'h0);
      meas;
      chk(32'd12, h, "high");
      $display("test pulse done");
      for (e = 0; e < 2; e = e + 1) begin
         cfg(`CAP_TWO_REG, e ? 8'h10 : 8'h00, `MODE_FREE);
         i_pin_model.pulse(1'b0, 40);
         repeat (10) @(posedge aclk);
         rd(`OFS_PERIOD, 2'h0, v);
         rd(`OFS_DUTY, 2'h0, w);
         v = {16'h0, e ? v[15:0] - w[15:0] : w[15:0] - v[15:0]};
         chk(32'd20, v, "width");
      end
      cfg(`CAP_ONE_REG, 8'h30, `MODE_FREE);
      i_pin_model.pulse(1'b0, 1);
      repeat (10) @(posedge aclk);
      rchk(`OFS_STATUS, 32'h0);
      i_pin_model.pulse(1'b0, 40);
      repeat (10) @(posedge aclk);
      rchk(`OFS_STATUS, 32'h2);
      cfg(`CAP_DUAL_INPUT, 8'hF0, `MODE_FREE);
      i_pin_model.pulse(1'b1, 40);
      repeat (10) @(posedge aclk);
      rchk(`OFS_STATUS, 32'h1);
      $display("test free capture done");
      cfg(`CAP_ONE_REG, 8'h10, `MODE_RESTART);
      i_pin_model.pulse(1'b0, 10);
      repeat (29) @(posedge aclk);
      i_pin_model.pulse(1'b0, 10);
      repeat (10) @(posedge aclk);
      rd(`OFS_DUTY, 2'h0, v);
      chk(32'd20, {16'h0, v[15:0]}, "reg_b");
      wr(`OFS_MASK, 32'h5, 2'h0);
      repeat (2) @(posedge aclk);
      chk(32'h1, {31'h0, irq}, "irq");
      wr(`OFS_STATUS, 32'h2, 2'h0);
      repeat (2) @(posedge aclk);
      chk(32'h0, {31'h0, irq}, "irq");
      $display("test restart done");
      print_verdict;
   end
endmodule // testbench
